//--- ipc_regs.svh
// Register offsets, field positions, reset values and counts of the input parity checker
`ifndef IPC_REGS_SVH
`define IPC_REGS_SVH
// ------------------------------------------------------------
// Device register offsets
// ------------------------------------------------------------
`define IPC_ERR_COUNT_OFS 8'h02
`define IPC_INT_ENABLE_OFS 8'h03
`define IPC_INT_STATUS_OFS 8'h04
`define IPC_PAR_CTRL_OFS 8'h20
`define IPC_DIV_CTRL_OFS 8'h22
`define IPC_PHASE_CTRL_OFS 8'h23
// ------------------------------------------------------------
// Device field positions
// ------------------------------------------------------------
`define IPC_PAR_INT_BIT 7
`define IPC_PMODE_LSB 0
`define IPC_WIDTH_LSB 2
`define IPC_INV_BIT 4
`define IPC_QUAD_BIT 5
`define IPC_DIV_LSB 4
`define IPC_PHASE_LSB 4
// ------------------------------------------------------------
// Reset values and counts
// ------------------------------------------------------------
`define IPC_PAR_CTRL_RST 8'h00
`define IPC_DIV_CTRL_RST 8'h10
`define IPC_PHASE_CTRL_RST 8'h00
`define IPC_INT_ENABLE_RST 8'h00
`define IPC_ERR_MAX 8'hFF
`define IPC_HALF_STEPS 4'h8
`define IPC_CNT_RST 4'hF
`define IPC_FRM_RST 3'h7
// ------------------------------------------------------------
// Source controller APB map
// ------------------------------------------------------------
`define IPC_SRC_CTRL_OFS 12'h000
`define IPC_SRC_CMD_OFS 12'h004
`define IPC_SRC_STAT_OFS 12'h008
`define IPC_SRC_RUN_BIT 0
`define IPC_SRC_INJ_BIT 1
`define IPC_SRC_WIDTH_LSB 2
`define IPC_SRC_PMODE_LSB 4
`define IPC_SRC_LVDS_BIT 6
`define IPC_SRC_CMD_WE_BIT 31
`define IPC_SRC_CMD_ADDR_LSB 8
`endif

//--- ipc_pkg.sv
// Types and shared decode of the input parity checker
package ipc_pkg;
    // ------------------------------------------------------------
    // Modes
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ipc_pm_off = 2'b00,
        ipc_pm_iq = 2'b01,
        ipc_pm_even = 2'b10,
        ipc_pm_odd = 2'b11
    } ipc_pmode_t;
    typedef enum logic [1:0] {
        ipc_w4 = 2'b00,
        ipc_w8 = 2'b01,
        ipc_w16 = 2'b10,
        ipc_w32 = 2'b11
    } ipc_width_t;
    // ------------------------------------------------------------
    // State records
    // ------------------------------------------------------------
    typedef struct packed {
        logic [2:0] pre;
        logic [3:0] cnt;
        logic [2:0] frm;
        logic dclk;
        logic fsync;
        logic [7:0] err_count;
        logic [7:0] int_enable;
        logic par_status;
        logic [7:0] par_ctrl;
        logic [7:0] div_ctrl;
        logic [7:0] phase_ctrl;
        logic [7:0] rdata;
        logic ack;
        logic irq;
        logic [31:0] cap_data;
        logic cap_valid;
        logic cap_rise;
    } ipc_dev_state_t;
    typedef struct packed {
        logic dclk_q;
        logic [31:0] word;
        logic pu;
        logic pl;
        logic [7:0] ctrl;
        logic busy;
        logic req;
        logic we;
        logic [7:0] addr;
        logic [7:0] wdata;
        logic [7:0] result;
        logic [15:0] sent;
        logic pready;
        logic [31:0] prdata;
        logic pslverr;
    } ipc_src_state_t;
    // Data bits covered by the lower parity for one bus width
    function automatic logic [31:0] ipc_lane_mask(input ipc_width_t w);
        case (w)
            ipc_w4: ipc_lane_mask = 32'h0000000F;
            ipc_w8: ipc_lane_mask = 32'h000000FF;
            default: ipc_lane_mask = 32'h0000FFFF;
        endcase
    endfunction
endpackage

//--- ipc_link_if.sv
// Link between the converter input port and the external data source
`timescale 1ns/100ps
interface ipc_link_if;
    // Data clock and frame sync made by the device
    logic source_data_clock_out;
    logic frame_sync_pulse;
    // Bus word and parity; on the differential bus the upper pin is diff_parity_pos
    // and the lower pin diff_parity_neg
    logic [31:0] data;
    logic parity_upper_input;
    logic parity_lower_input;
    // Interface-select straps
    logic sel_ctrl;
    logic sel_bus;
    // Shared interrupt pin
    logic irq;
    // Serial-port register access, modelled as a request/ack port
    logic reg_req;
    logic reg_we;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic [7:0] reg_rdata;
    logic reg_ack;
    modport device (
        output source_data_clock_out, frame_sync_pulse, irq, reg_rdata, reg_ack,
        input data, parity_upper_input, parity_lower_input, sel_ctrl, sel_bus,
        input reg_req, reg_we, reg_addr, reg_wdata
    );
    modport source (
        input source_data_clock_out, frame_sync_pulse, irq, reg_rdata, reg_ack,
        output data, parity_upper_input, parity_lower_input, sel_ctrl, sel_bus,
        output reg_req, reg_we, reg_addr, reg_wdata
    );
endinterface

//--- ipc_device.sv
// Converter input port: bus sampling, parity check, error counter and interrupt
// ------------------------------------------------------------
// ------------------------------------------------------------
//
// A request/ack register port, modelling the serial port, was chosen for this implementation.
`timescale 1ns/100ps
`include "ipc_regs.svh"
module ipc_device (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Link toward the data source
    ipc_link_if.device link,
    // Captured words toward the datapath
    output logic [31:0] sample_data,
    output logic sample_valid,
    output logic sample_rise
);
    import ipc_pkg::*;

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    ipc_dev_state_t s; // Registered state
    ipc_dev_state_t next_s; // Next state
    logic [2:0] div_last; // Last prescale count of one step
    logic [3:0] phase; // Sampling phase field
    logic tick; // First pclk of a phase step
    logic rise_ev; // Internal sampling clock rising
    logic fall_ev; // Internal sampling clock falling
    logic lvds_bus; // Differential bus selected
    logic cmos_bus; // Parallel-pin bus selected
    logic capture; // A word is taken this cycle
    logic err; // Parity error on the taken word
    logic wr; // Register write request
    ipc_width_t width; // Effective bus width
    ipc_pmode_t pmode; // Parity checking mode

    // ------------------------------------------------------------
    // Parity check of one captured word
    // ------------------------------------------------------------
    // Returns one when the word breaks the selected parity mode
    function automatic logic parity_fault(
        input logic [31:0] d,
        input logic pu,
        input logic pl,
        input ipc_width_t w,
        input ipc_pmode_t m,
        input logic lvds,
        input logic rise
    );
        logic odd;
        logic lo;
        logic hi;
        begin
            odd = (m == ipc_pm_odd);
            lo = ^(d & ipc_lane_mask(w)) ^ odd;
            hi = ^d[31:16] ^ odd;
            parity_fault = 1'b0;
            if (m == ipc_pm_off) begin
                parity_fault = 1'b0;
            end else if (lvds) begin
                if (m == ipc_pm_iq) begin
                    // rising expects 0, falling expects 1
                    // no pattern check below 32 bits
                    parity_fault = (w == ipc_w32) && (pu != !rise);
                end else begin
                    // ones count with the parity bit
                    parity_fault = lo ^ pu;
                end
            end else begin
                if (m == ipc_pm_iq) begin
                    // upper carries I (0), lower Q (1)
                    parity_fault = pu || !pl;
                end else begin
                    // upper input only counts at 32 bits
                    parity_fault = (lo ^ pl) || ((w == ipc_w32) && (hi ^ pu));
                end
            end
        end
    endfunction

    // ------------------------------------------------------------
    // Sampling clock and bus mode decode
    // ------------------------------------------------------------
    // divider field zero behaves as one, so a period is never shorter than 16 pclk
    assign div_last = (s.div_ctrl[`IPC_DIV_LSB +: 3] == 3'h0) ? 3'h0 : s.div_ctrl[`IPC_DIV_LSB +: 3] - 3'h1;
    assign phase = s.phase_ctrl[`IPC_PHASE_LSB +: 4];
    assign tick = (s.pre == 3'h0);
    // sampling edges offset from the data clock by the phase steps
    assign rise_ev = tick && (s.cnt == phase);
    assign fall_ev = tick && (s.cnt == 4'(phase + `IPC_HALF_STEPS));
    // both selects low picks the differential bus
    assign lvds_bus = !link.sel_ctrl && !link.sel_bus;
    assign cmos_bus = link.sel_ctrl && link.sel_bus;
    // quad upconverter mode forces the full width
    assign width = s.par_ctrl[`IPC_QUAD_BIT] ? ipc_w32 : ipc_width_t'(s.par_ctrl[`IPC_WIDTH_LSB +: 2]);
    assign pmode = ipc_pmode_t'(s.par_ctrl[`IPC_PMODE_LSB +: 2]);
    // parallel bus takes words on the rising sampling edge
    // differential bus takes words on the falling edge
    // and on the rising edge too, but only at 32 bits
    assign capture = (cmos_bus && rise_ev) || (lvds_bus && (fall_ev || ((width == ipc_w32) && rise_ev)));
    // relies on the source holding the word around the chosen edge
    assign err = capture && parity_fault(link.data, link.parity_upper_input, link.parity_lower_input,
        width, pmode, lvds_bus, rise_ev);
    assign wr = link.reg_req && link.reg_we;

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    // Mixed strap values pick neither bus, so nothing is sampled then
    always_comb begin
        next_s = s;
        next_s.ack = link.reg_req;
        next_s.cap_valid = capture;
        // Prescaler and sixteen-step phase counter
        if (s.pre >= div_last) begin
            next_s.pre = 3'h0;
            next_s.cnt = s.cnt + 4'h1;
            if (s.cnt == 4'hF) begin
                next_s.frm = s.frm + 3'h1;
            end
        end else begin
            next_s.pre = s.pre + 3'h1;
        end
        // data clock high for the first half of each period, low instead when the invert bit is set
        next_s.dclk = (next_s.cnt < `IPC_HALF_STEPS) ^ s.par_ctrl[`IPC_INV_BIT];
        // Frame sync marks one data clock period in eight
        next_s.fsync = (next_s.frm == 3'h0);
        // Word capture toward the datapath
        if (capture) begin
            next_s.cap_data = link.data;
            next_s.cap_rise = rise_ev;
        end
        // Register writes
        if (wr) begin
            case (link.reg_addr)
                `IPC_INT_ENABLE_OFS: begin
                    next_s.int_enable = link.reg_wdata;
                end
                `IPC_PAR_CTRL_OFS: begin
                    next_s.par_ctrl = link.reg_wdata;
                end
                `IPC_DIV_CTRL_OFS: begin
                    next_s.div_ctrl = link.reg_wdata;
                end
                `IPC_PHASE_CTRL_OFS: begin
                    next_s.phase_ctrl = link.reg_wdata;
                end
                default: begin
                end
            endcase
        end
        // write one to status bit seven clears count and interrupt
        if (wr && (link.reg_addr == `IPC_INT_STATUS_OFS) && link.reg_wdata[`IPC_PAR_INT_BIT]) begin
            next_s.err_count = 8'h00;
            next_s.par_status = 1'b0;
        end
        // A new error after the clear wins over it, so none is lost
        if (err) begin
            if (next_s.err_count != `IPC_ERR_MAX) begin
                next_s.err_count = next_s.err_count + 8'h01;
            end
            if (s.int_enable[`IPC_PAR_INT_BIT]) begin
                next_s.par_status = 1'b1;
            end
        end
        next_s.irq = next_s.par_status && next_s.int_enable[`IPC_PAR_INT_BIT];
        // Register reads answer the cycle after the request
        if (link.reg_req && !link.reg_we) begin
            case (link.reg_addr)
                `IPC_ERR_COUNT_OFS: begin
                    next_s.rdata = s.err_count;
                end
                `IPC_INT_ENABLE_OFS: begin
                    next_s.rdata = s.int_enable;
                end
                // status readable so the host can find the cause
                `IPC_INT_STATUS_OFS: begin
                    next_s.rdata = {s.par_status, 7'h00};
                end
                `IPC_PAR_CTRL_OFS: begin
                    next_s.rdata = s.par_ctrl;
                end
                `IPC_DIV_CTRL_OFS: begin
                    next_s.rdata = s.div_ctrl;
                end
                `IPC_PHASE_CTRL_OFS: begin
                    next_s.rdata = s.phase_ctrl;
                end
                default: begin
                    next_s.rdata = 8'h00;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    // counter and status start at zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
            // Counters start on their last step so the first clock half and frame are full length
            s.cnt <= `IPC_CNT_RST;
            s.frm <= `IPC_FRM_RST;
            s.par_ctrl <= `IPC_PAR_CTRL_RST;
            s.div_ctrl <= `IPC_DIV_CTRL_RST;
            s.phase_ctrl <= `IPC_PHASE_CTRL_RST;
            s.int_enable <= `IPC_INT_ENABLE_RST;
        end else begin
            s <= next_s;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign link.source_data_clock_out = s.dclk;
    assign link.frame_sync_pulse = s.fsync;
    assign link.irq = s.irq;
    assign link.reg_rdata = s.rdata;
    assign link.reg_ack = s.ack;
    assign sample_data = s.cap_data;
    assign sample_valid = s.cap_valid;
    assign sample_rise = s.cap_rise;
endmodule

//--- ipc_source.sv
// External data source: word and parity generator with APB control of the device registers
`timescale 1ns/100ps
`include "ipc_regs.svh"
module ipc_source (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Link toward the device
    ipc_link_if.source link
);
    import ipc_pkg::*;

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    ipc_src_state_t s; // Registered state
    ipc_src_state_t next_s; // Next state
    logic access; // APB access phase not yet answered
    logic commit; // APB access completing this edge
    logic dclk_edge; // Data clock changed
    logic dclk_rise; // Data clock rose
    logic lvds; // Differential bus selected
    logic launch; // New word goes out
    logic odd; // Odd parity selected
    logic lo; // Parity of the lower lane
    logic hi; // Parity of the upper half
    logic [31:0] w; // Next word
    ipc_width_t width; // Bus width
    ipc_pmode_t pmode; // Parity mode

    // ------------------------------------------------------------
    // Launch decode
    // ------------------------------------------------------------
    assign access = psel && penable && !s.pready;
    assign commit = psel && penable && s.pready;
    assign lvds = s.ctrl[`IPC_SRC_LVDS_BIT];
    assign width = ipc_width_t'(s.ctrl[`IPC_SRC_WIDTH_LSB +: 2]);
    assign pmode = ipc_pmode_t'(s.ctrl[`IPC_SRC_PMODE_LSB +: 2]);
    assign dclk_edge = link.source_data_clock_out != s.dclk_q;
    assign dclk_rise = dclk_edge && link.source_data_clock_out;
    // words change on the data clock edges only, so they hold around the sampling edge
    assign launch = s.ctrl[`IPC_SRC_RUN_BIT] && (dclk_rise || (dclk_edge && lvds && (width == ipc_w32)));
    assign w = s.word + 32'h00000001;
    assign odd = (pmode == ipc_pm_odd);
    assign lo = ^(w & ipc_lane_mask(width)) ^ odd;
    assign hi = ^w[31:16] ^ odd;

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        next_s = s;
        next_s.dclk_q = link.source_data_clock_out;
        next_s.req = 1'b0;
        next_s.pready = access;
        next_s.pslverr = 1'b0;
        // every launched word carries a fresh parity bit
        if (launch) begin
            next_s.word = w;
            next_s.sent = s.sent + 16'h0001;
            if (lvds) begin
                next_s.pu = ((pmode == ipc_pm_iq) ? !dclk_rise : lo) ^ s.ctrl[`IPC_SRC_INJ_BIT];
                next_s.pl = !next_s.pu;
            end else if (pmode == ipc_pm_iq) begin
                next_s.pu = 1'b0;
                next_s.pl = !s.ctrl[`IPC_SRC_INJ_BIT];
            end else begin
                next_s.pu = (width == ipc_w32) ? hi : 1'b0;
                next_s.pl = lo ^ s.ctrl[`IPC_SRC_INJ_BIT];
            end
            // Error injection spoils only one word
            next_s.ctrl[`IPC_SRC_INJ_BIT] = 1'b0;
        end
        // Device answer ends the register command
        if (link.reg_ack) begin
            next_s.busy = 1'b0;
            next_s.result = link.reg_rdata;
        end
        // APB read data loaded at the same edge that raises pready
        if (access) begin
            case (paddr)
                `IPC_SRC_CTRL_OFS: begin
                    next_s.prdata = {24'h000000, s.ctrl};
                end
                `IPC_SRC_CMD_OFS: begin
                    next_s.prdata = {s.we, 15'h0000, s.addr, s.wdata};
                end
                `IPC_SRC_STAT_OFS: begin
                    next_s.prdata = {s.sent, 6'h00, link.irq, s.busy, s.result};
                end
                default: begin
                    next_s.prdata = 32'h00000000;
                    next_s.pslverr = 1'b1;
                end
            endcase
        end
        // APB writes take effect at the edge that sees pready
        if (commit && pwrite) begin
            case (paddr)
                `IPC_SRC_CTRL_OFS: begin
                    next_s.ctrl = pwdata[7:0];
                end
                // host polls status through this command path
                `IPC_SRC_CMD_OFS: begin
                    // A command while one is open is dropped
                    if (!s.busy) begin
                        next_s.busy = 1'b1;
                        next_s.req = 1'b1;
                        next_s.we = pwdata[`IPC_SRC_CMD_WE_BIT];
                        next_s.addr = pwdata[`IPC_SRC_CMD_ADDR_LSB +: 8];
                        next_s.wdata = pwdata[7:0];
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // straps: both low for differential, both high for parallel
    assign link.sel_ctrl = !s.ctrl[`IPC_SRC_LVDS_BIT];
    assign link.sel_bus = !s.ctrl[`IPC_SRC_LVDS_BIT];
    assign link.data = s.word;
    assign link.parity_upper_input = s.pu;
    assign link.parity_lower_input = s.pl;
    assign link.reg_req = s.req;
    assign link.reg_we = s.we;
    assign link.reg_addr = s.addr;
    assign link.reg_wdata = s.wdata;
    assign prdata = s.prdata;
    assign pready = s.pready;
    assign pslverr = s.pslverr;
endmodule

//--- ipc_link_monitor.sv
// Concurrent checks on the link between the converter input port and its source
`timescale 1ns/100ps
module ipc_link_monitor (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Link signals
    input wire logic source_data_clock_out,
    input wire logic frame_sync_pulse,
    input wire logic irq,
    input wire logic reg_req,
    input wire logic reg_we,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_ack
);
    // ------------------------------------------------------------
    // Checks, all in the pclk domain
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Halves of the data clock; divider is left at one so each lasts eight pclk
    sequence hi_s; source_data_clock_out [*8]; endsequence
    sequence lo_s; !source_data_clock_out [*8]; endsequence
    sequence clr_s; reg_req && reg_we && reg_addr == 8'h04 && reg_wdata[7]; endsequence
    sequence mask_s; reg_req && reg_we && reg_addr == 8'h03 && !reg_wdata[7]; endsequence
    ack_next_a: assert property (reg_req |=> reg_ack) else $error("request not acknowledged");
    ack_cause_a: assert property (reg_ack |-> $past(reg_req)) else $error("acknowledge without request");
    rdata_hold_a: assert property ($changed(reg_rdata) |-> reg_ack) else $error("read data moved without ack");
    unmapped_zero_a: assert property (reg_req && !reg_we && reg_addr == 8'h10 |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    dclk_shape_a: assert property ($rose(source_data_clock_out) |-> hi_s ##1 lo_s ##1 source_data_clock_out)
        else $error("data clock period wrong");
    frame_len_a: assert property ($rose(frame_sync_pulse) |-> frame_sync_pulse [*8] ##1 frame_sync_pulse [*8]
        ##1 !frame_sync_pulse) else $error("frame sync width wrong");
    irq_mask_a: assert property (mask_s |-> ##[1:2] !irq) else $error("masked interrupt still high");
    irq_clear_a: assert property (clr_s |-> ##[1:2] !irq) else $error("cleared interrupt still high");
endmodule

//--- input_bus_sampling_parity_checker_test.sv
// Bench joining the device and the data source over the link
`timescale 1ns/100ps
module input_bus_sampling_parity_checker_test;
    // Clock, reset and APB master side
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic pready;
    logic pslverr;
    logic se;
    logic [31:0] sd;
    logic sv;
    logic sr;
    logic [7:0] caps = 8'h00;
    logic [7:0] c0;
    int fails = 0;
    int checks_done = 0;
    // Rows: device control, source control, phase field, expected count after one bad word
    logic [31:0] rows [10] = '{32'h06251001, 32'h03311001, 32'h09191001, 32'h0C0D1000, 32'h0B791001,
        32'h05551000, 32'h0D5D4001, 32'h0E6D4001, 32'h222D1001, 32'h0E2D1001};
    // Reset values: offset then value
    logic [15:0] rst_v [6] = '{16'h0200, 16'h0300, 16'h0400, 16'h2000, 16'h2210, 16'h2300};
    ipc_link_if link ();
    ipc_device ipc_device_inst (.pclk(pclk), .presetn(presetn), .link(link.device), .sample_data(sd),
        .sample_valid(sv), .sample_rise(sr));
    ipc_source ipc_source_inst (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link.source));
    ipc_link_monitor ipc_link_monitor_inst (.pclk(pclk), .presetn(presetn),
        .source_data_clock_out(link.source_data_clock_out), .frame_sync_pulse(link.frame_sync_pulse),
        .irq(link.irq), .reg_req(link.reg_req), .reg_we(link.reg_we), .reg_addr(link.reg_addr),
        .reg_wdata(link.reg_wdata), .reg_rdata(link.reg_rdata), .reg_ack(link.reg_ack));
    // 200 MHz clock
    initial forever #2.5 pclk = ~pclk;
    // Count captures; words change away from the sampling edges, so a capture still matches the bus
    always @(posedge pclk) begin
        if (sv) begin
            caps <= caps + 8'h01;
            chk(sd[7:0], link.data[7:0]);
        end
    end
    // Compare and count
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // One APB transfer; held until pready is seen at an edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        se = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Device register access through the source; waits while busy, rd[7:0] is read data
    task automatic dw(input logic [7:0] a, input logic [7:0] d, input logic w = 1'b1);
        apb(1'b1, 12'h004, {w, 15'h0000, a, d});
        do apb(1'b0, 12'h008, 32'h00000000); while (rd[8] !== 1'b0);
    endtask
    task automatic report_and_stop;
        if (fails == 0 && checks_done > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        foreach (rst_v[i]) begin
            dw(rst_v[i][15:8], 8'h00, 1'b0);
            chk(rd[7:0], rst_v[i][7:0]);
        end
        dw(8'h10, 8'h00, 1'b0);
        chk(rd[7:0], 8'h00);
        apb(1'b0, 12'h100, 32'h00000000);
        chk({7'h00, se}, 8'h01);
        // Each row: configure, settle, clear, then send one bad word
        foreach (rows[i]) begin
            dw(8'h20, rows[i][31:24]);
            dw(8'h23, rows[i][15:8]);
            apb(1'b1, 12'h000, {24'h000000, rows[i][23:16]});
            repeat (100) @(posedge pclk);
            dw(8'h04, 8'h80);
            apb(1'b1, 12'h000, {24'h000000, rows[i][23:16] | 8'h02});
            c0 = caps;
            // Eighteen data clock periods: one word each, two on the 32-bit differential bus
            repeat (288) @(posedge pclk);
            chk(caps - c0, (rows[i][22] && rows[i][19:18] == 2'b11) ? 8'h24 : 8'h12);
            if (!(rows[i][22] && rows[i][19:18] == 2'b11)) chk({7'h00, sr}, {7'h00, !rows[i][22]});
            dw(8'h02, 8'h00, 1'b0);
            chk(rd[7:0], rows[i][7:0]);
        end
        // Interrupt raised, masked, then cleared
        dw(8'h03, 8'h80);
        apb(1'b1, 12'h000, 32'h0000002F);
        repeat (300) @(posedge pclk);
        dw(8'h04, 8'h00, 1'b0);
        chk(rd[7:0], 8'h80);
        chk({7'h00, rd[9]}, 8'h01);
        dw(8'h03, 8'h00);
        apb(1'b0, 12'h008, 32'h00000000);
        chk({7'h00, rd[9]}, 8'h00);
        dw(8'h03, 8'h80);
        chk({7'h00, rd[9]}, 8'h01);
        dw(8'h04, 8'h80);
        chk({7'h00, rd[9]}, 8'h00);
        dw(8'h02, 8'h55);
        dw(8'h02, 8'h00, 1'b0);
        chk(rd[7:0], 8'h00);
        dw(8'h04, 8'h00, 1'b0);
        chk(rd[7:0], 8'h00);
        // Source sends odd while device checks even: every word fails
        apb(1'b1, 12'h000, 32'h0000003D);
        repeat (4500) @(posedge pclk);
        dw(8'h02, 8'h00, 1'b0);
        chk(rd[7:0], 8'hFF);
        report_and_stop();
    end
    // Hang guard
    initial begin
        repeat (40000) @(posedge pclk);
        fails++;
        report_and_stop();
    end
endmodule
